// ===== bench/burst_link_asserts.sv
`timescale 1ns/1ps
module burst_link_asserts (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic radio_system_clock,
	input wire logic serial_transfer_enable,
	input wire logic serial_transfer_data,
	input wire logic rx_transfer_enable,
	input wire logic rx_transfer_data,
	input wire logic receive_frame_marker,
	input wire logic strobe,
	input wire logic control_link_clock,
	input wire logic control_link_data,
	input wire logic control_link_enable
);
	logic cclk_reg;
	logic [5:0] rise_cnt_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cclk_reg <= 1'h0;
		end else begin
			cclk_reg <= control_link_clock;
		end
	end
	// Rises per frame; cleared while the link is deselected
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rise_cnt_reg <= 6'h00;
		end else if (!control_link_enable) begin
			rise_cnt_reg <= 6'h00;
		end else if (control_link_clock && !cclk_reg) begin
			rise_cnt_reg <= rise_cnt_reg + 6'h01;
		end
	end
	////////////////////////////////
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	a_radio_clk_shape: assert property ($rose(radio_system_clock) |-> radio_system_clock[*5] ##1
		!radio_system_clock[*5] ##1 radio_system_clock) else $error("radio clock shape wrong");
	a_marker_needs_en: assert property (receive_frame_marker |-> rx_transfer_enable)
		else $error("marker outside enable");
	a_rx_first_marker: assert property ($rose(rx_transfer_enable) |-> receive_frame_marker)
		else $error("first receive bit lacks marker");
	a_rx_on_fall: assert property (($changed(rx_transfer_data) || $changed(rx_transfer_enable))
		|-> !radio_system_clock) else $error("receive line moved while clock high");
	a_tx_on_fall: assert property (($changed(serial_transfer_data) || $changed(serial_transfer_enable))
		|-> !radio_system_clock) else $error("transmit line moved while clock high");
	a_ctrl_clk_shape: assert property ($rose(control_link_clock) |-> control_link_clock[*4]
		##1 !control_link_clock) else $error("control clock high time wrong");
	a_ctrl_clk_framed: assert property ($rose(control_link_clock) |-> control_link_enable)
		else $error("control clock outside frame");
	a_word_bit_count: assert property ($fell(control_link_enable) |-> rise_cnt_reg == 6'h18)
		else $error("control word not 24 bits");
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam logic [15:0] DEF_RAMP = 16'h0A5C;
	// Short symbol divider keeps two full bursts inside the run budget
	localparam int SYM_DIV_TB = 16;
	localparam int MAX_CYCLES = 2 * 148 * SYM_DIV_TB * 2 * burst_link_pkg::RCLK_HALF + 12000;
	logic [15:0] cordic_phase, amplitude, phase_step;
	logic mclk = 1'h0;
	logic rstn = 1'h0;
	logic tx_bit = 1'h0;
	logic tx_bit_valid = 1'h0;
	logic start_strobe = 1'h0;
	logic ctrl_valid = 1'h0;
	logic rx_word_valid = 1'h0;
	logic [23:0] ctrl_word = 24'h000000;
	logic [15:0] rx_word = 16'h0000;
	logic tx_bit_ready, ctrl_busy, rx_bit, rx_bit_valid, rx_frame_start, rx_word_ready;
	logic symbol_valid, burst_active, psk_mode, defaults_loaded;
	logic [2:0] symbol;
	logic [15:0] ramp_level;
	logic [15:0] ramp_exp;
	logic [2:0] syms[$];
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	int seed = 42;
	always #4 mclk = ~mclk;
	burst_link_if link();
	transmit_modulation_module #(.DEFAULT_RAMP(DEF_RAMP), .SYM_DIV(SYM_DIV_TB))
		u_transmit_modulation_module (.mclk(mclk), .rstn(rstn),
		.link(link), .rx_word(rx_word), .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready),
		.symbol(symbol), .symbol_valid(symbol_valid), .burst_active(burst_active), .psk_mode(psk_mode),
		.cordic_phase(cordic_phase), .amplitude(amplitude), .phase_step(phase_step), .ramp_level(ramp_level),
		.defaults_loaded(defaults_loaded));
	baseband_burst_source u_baseband_burst_source (.mclk(mclk), .rstn(rstn), .link(link), .tx_bit(tx_bit),
		.tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready), .start_strobe(start_strobe),
		.ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid), .ctrl_busy(ctrl_busy), .rx_bit(rx_bit),
		.rx_bit_valid(rx_bit_valid), .rx_frame_start(rx_frame_start));
	burst_link_asserts u_burst_link_asserts (.mclk(mclk), .rstn(rstn),
		.radio_system_clock(link.radio_system_clock), .serial_transfer_enable(link.serial_transfer_enable),
		.serial_transfer_data(link.serial_transfer_data), .rx_transfer_enable(link.rx_transfer_enable),
		.rx_transfer_data(link.rx_transfer_data), .receive_frame_marker(link.receive_frame_marker),
		.strobe(link.strobe), .control_link_clock(link.control_link_clock),
		.control_link_data(link.control_link_data), .control_link_enable(link.control_link_enable));
	////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Ceiling: two bursts plus link traffic, with margin
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == MAX_CYCLES) begin
			failures++;
			end_of_test();
		end
	end
	always @(negedge mclk) begin
		if (symbol_valid === 1'h1 && burst_active === 1'h1) begin
			syms.push_back(symbol);
		end
	end
	function automatic logic [2:0] exp_sym(input int i, input logic psk, input logic b);
		if (i < 3 || i > 144) begin
			return psk ? burst_link_pkg::PSK_TAIL : burst_link_pkg::GMSK_TAIL;
		end
		return psk ? {3{b}} : {2'h0, b};
	endfunction
	////////////////////////////////
	task automatic ctrl_write(input logic [23:0] w);
		@(negedge mclk);
		ctrl_word = w;
		ctrl_valid = 1'h1;
		@(negedge mclk);
		ctrl_valid = 1'h0;
		for (int k = 0; k < 1000 && ctrl_busy !== 1'h0; k++) @(negedge mclk);
		repeat (16) @(negedge mclk);
	endtask
	task automatic rx_check(input logic [15:0] w);
		logic [15:0] acc;
		acc = 16'h0000;
		for (int k = 0; k < 2000 && rx_word_ready !== 1'h1; k++) @(negedge mclk);
		rx_word = w;
		rx_word_valid = 1'h1;
		@(negedge mclk);
		rx_word_valid = 1'h0;
		for (int n = 0; n < 16; n++) begin
			for (int k = 0; k < 200 && rx_bit_valid !== 1'h1; k++) @(negedge mclk);
			if (n == 0) check(rx_frame_start, 1);
			acc = {acc[14:0], rx_bit};
			@(negedge mclk);
		end
		check(acc, w);
	endtask
	task automatic burst(input logic psk, input logic b);
		int n;
		n = 0;
		syms.delete();
		tx_bit = b;
		tx_bit_valid = 1'h1;
		@(negedge mclk);
		start_strobe = 1'h1;
		@(negedge mclk);
		start_strobe = 1'h0;
		for (int k = 0; k < 2000 && burst_active !== 1'h1; k++) @(negedge mclk);
		check(psk_mode, psk);
		while (burst_active === 1'h1 && n < 80000) begin
			@(negedge mclk);
			n++;
		end
		check(n, 148 * SYM_DIV_TB * 2 * burst_link_pkg::RCLK_HALF);
		check(syms.size(), 148);
		foreach (syms[i]) check(syms[i], exp_sym(i, psk, b));
		tx_bit_valid = 1'h0;
		for (int k = 0; k < 1000 && symbol_valid !== 1'h1; k++) @(negedge mclk);
		check(symbol, psk ? 3'h7 : 3'h1);
		// Polar paths follow the symbol one clock later
		@(negedge mclk);
		check(amplitude, 16'h7FFF);
		check(phase_step, psk ? 16'h0000 : 16'h4000);
		if (psk) check(cordic_phase, 16'hE000);
	endtask
	////////////////////////////////
	initial begin
		repeat (12) @(negedge mclk);
		rstn = 1'h1;
		repeat (2) @(negedge mclk);
		check(defaults_loaded, 1);
		check(ramp_level, DEF_RAMP);
		check(psk_mode, 0);
		for (int k = 0; k < 1000 && symbol_valid !== 1'h1; k++) @(negedge mclk);
		check(symbol, 3'h1);
		repeat (2) rx_check(16'($random(seed)));
		rx_check(16'h8001);
		ramp_exp = 16'($random(seed));
		ctrl_write({1'h1, burst_link_pkg::RAMP_REG_ADDR, ramp_exp});
		check(ramp_level, ramp_exp);
		// Reads and unmapped writes must leave the level alone
		ctrl_write({1'h0, burst_link_pkg::RAMP_REG_ADDR, ~ramp_exp});
		check(ramp_level, ramp_exp);
		ctrl_write({1'h1, 7'h05, ~ramp_exp});
		check(ramp_level, ramp_exp);
		burst(1'h0, 1'($random(seed)));
		ctrl_write({1'h1, burst_link_pkg::MODE_REG_ADDR, 16'h0001});
		burst(1'h1, 1'h0);
		end_of_test();
	end
endmodule

// ===== common/burst_link_if.sv
`timescale 1ns/1ps
interface burst_link_if;
	logic radio_system_clock;
	logic serial_transfer_enable;
	logic serial_transfer_data;
	logic rx_transfer_enable;
	logic rx_transfer_data;
	logic receive_frame_marker;
	logic strobe;
	logic control_link_clock;
	logic control_link_data;
	logic control_link_enable;
	modport device (
		output radio_system_clock,
		input serial_transfer_enable,
		input serial_transfer_data,
		output rx_transfer_enable,
		output rx_transfer_data,
		output receive_frame_marker,
		input strobe,
		input control_link_clock,
		input control_link_data,
		input control_link_enable
	);
	modport baseband (
		input radio_system_clock,
		output serial_transfer_enable,
		output serial_transfer_data,
		input rx_transfer_enable,
		input rx_transfer_data,
		input receive_frame_marker,
		output strobe,
		output control_link_clock,
		output control_link_data,
		output control_link_enable
	);
endinterface

// ===== common/burst_link_pkg.sv
package burst_link_pkg;
	// Reference timing: 125 MHz local clock, 13 MHz radio reference
	localparam int unsigned MCLK_HZ = 125000000;
	localparam int unsigned REF_HZ = 13000000;
	localparam int unsigned SYM_DIV = 48;
	// Local cycles per half period of the divided radio clock
	localparam int unsigned RCLK_HALF = (MCLK_HZ + REF_HZ) / (2 * REF_HZ);
	localparam int unsigned SYM_REF_CYC = SYM_DIV;
	localparam int unsigned BURST_SYMS = 148;
	localparam int unsigned USEFUL_PERIODS = BURST_SYMS - 1;
	localparam int unsigned TAIL_SYMS = 3;
	localparam int unsigned PAYLOAD_SYMS = BURST_SYMS - 2 * TAIL_SYMS;
	localparam int unsigned PSK_BITS = 3;
	localparam logic [2:0] GMSK_TAIL = 3'h0;
	localparam logic [2:0] PSK_TAIL = 3'h7;
	localparam logic [2:0] PSK_IDLE = 3'h7;
	localparam logic GMSK_IDLE_BIT = 1'h1;
	// Control link word: 1 write bit, 7 address bits, 16 data bits
	localparam int unsigned CTRL_ADDR_W = 7;
	localparam int unsigned CTRL_DATA_W = 16;
	localparam int unsigned CTRL_WORD_W = 1 + CTRL_ADDR_W + CTRL_DATA_W;
	localparam int unsigned CTRL_REGS = 8;
	localparam logic [6:0] MODE_REG_ADDR = 7'h00;
	localparam logic [6:0] RAMP_REG_ADDR = 7'h01;
	localparam int unsigned MODE_PSK_BIT = 0;
	localparam int unsigned CTRL_HALF = 4;
	typedef enum logic [1:0] {
		MOD_GMSK = 2'h0,
		MOD_PSK = 2'h1
	} mod_e;
endpackage

// ===== rtl/baseband_burst_source.sv
`timescale 1ns/1ps
module baseband_burst_source (
	input wire logic mclk,
	input wire logic rstn,
	burst_link_if.baseband link,
	input wire logic tx_bit,
	input wire logic tx_bit_valid,
	output logic tx_bit_ready,
	input wire logic start_strobe,
	input wire logic [23:0] ctrl_word,
	input wire logic ctrl_valid,
	output logic ctrl_busy,
	output logic rx_bit,
	output logic rx_bit_valid,
	output logic rx_frame_start
);
	////////////////////////////////////////////////////////////////
	// Synchronise device outputs
	logic [3:0] s1_reg;
	logic [3:0] s2_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s1_reg <= 4'h0;
			s2_reg <= 4'h0;
		end else begin
			s1_reg <= {link.radio_system_clock, link.rx_transfer_enable,
				link.rx_transfer_data, link.receive_frame_marker};
			s2_reg <= s1_reg;
		end
	end
	logic rclk_d_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rclk_d_reg <= 1'b0;
		end else begin
			rclk_d_reg <= s2_reg[3];
		end
	end
	wire rclk_fall = !s2_reg[3] && rclk_d_reg;
	wire rclk_rise = s2_reg[3] && !rclk_d_reg;

	////////////////////////////////////////////////////////////////
	// Transmit bits: change on falling edge of radio clock
	logic en_reg;
	logic dat_reg;
	logic rdy_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			en_reg <= 1'b0;
			dat_reg <= 1'b0;
			rdy_reg <= 1'b0;
		end else begin
			rdy_reg <= rclk_fall;
			// Enable drops only when no bit follows, so no gap reaches the sampling rise
			if (rdy_reg) begin
				en_reg <= tx_bit_valid; // RQ10
				if (tx_bit_valid) dat_reg <= tx_bit; // RQ10
			end
		end
	end
	assign link.serial_transfer_enable = en_reg;
	assign link.serial_transfer_data = dat_reg;
	assign tx_bit_ready = rdy_reg;

	logic strobe_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			strobe_reg <= 1'b0;
		end else begin
			strobe_reg <= start_strobe; // RQ13
		end
	end
	assign link.strobe = strobe_reg;

	////////////////////////////////////////////////////////////////
	// Control master: word MSB first, clock from divider
	logic [23:0] cw_reg;
	logic [4:0] cbits_reg;
	logic [2:0] cdiv_reg;
	logic cclk_reg;
	logic cen_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cw_reg <= 24'h000000;
			cbits_reg <= 5'h00;
			cdiv_reg <= 3'h0;
			cclk_reg <= 1'b0;
			cen_reg <= 1'b0;
		end else if (!cen_reg) begin
			cclk_reg <= 1'b0;
			if (ctrl_valid) begin
				cw_reg <= ctrl_word; // RQ14
				cbits_reg <= 5'(burst_link_pkg::CTRL_WORD_W);
				cen_reg <= 1'b1; // RQ15
				cdiv_reg <= 3'h0;
			end
		end else if (cdiv_reg == 3'(burst_link_pkg::CTRL_HALF - 1)) begin
			cdiv_reg <= 3'h0;
			if (cclk_reg) begin
				cclk_reg <= 1'b0;
				cw_reg <= {cw_reg[22:0], 1'b0};
				if (cbits_reg == 5'h01) cen_reg <= 1'b0;
				cbits_reg <= cbits_reg - 5'h01;
			end else begin
				cclk_reg <= 1'b1; // RQ15
			end
		end else begin
			cdiv_reg <= cdiv_reg + 3'h1;
		end
	end
	assign link.control_link_clock = cclk_reg;
	assign link.control_link_data = cw_reg[23];
	assign link.control_link_enable = cen_reg;
	assign ctrl_busy = cen_reg;

	////////////////////////////////////////////////////////////////
	// Receive capture on radio clock rising
	logic rxb_reg;
	logic rxv_reg;
	logic rxf_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rxb_reg <= 1'b0;
			rxv_reg <= 1'b0;
			rxf_reg <= 1'b0;
		end else begin
			rxv_reg <= rclk_rise && s2_reg[2]; // RQ12
			rxf_reg <= rclk_rise && s2_reg[2] && s2_reg[0]; // RQ12
			if (rclk_rise) rxb_reg <= s2_reg[1];
		end
	end
	assign rx_bit = rxb_reg;
	assign rx_bit_valid = rxv_reg;
	assign rx_frame_start = rxf_reg;
endmodule

// ===== rtl/transmit_modulation_module.sv
`timescale 1ns/1ps
// Behaviour
// [RQ1] Two schemes, GMSK and 8-PSK, polar out
// [RQ2] CORDIC path and phase derivative path
// [RQ3] One symbol per symbol period
// [RQ4] GMSK one bit, 8-PSK three bits
// [RQ5] GMSK idle is endless ones
// [RQ6] 8-PSK idle is all-ones symbol
// [RQ7] Three tail symbols each burst end
// [RQ8] Tails: 0 in GMSK, 7 in 8-PSK
// [RQ9] 148 symbols, 147 useful periods
// [RQ10] Baseband sends bits with enable
// [RQ11] Device sources radio system clock
// [RQ12] Receive data with enable and marker
// [RQ13] Baseband strobe starts transmit/receive; here it arms only the transmit burst, receive words start on rx_word_valid
// [RQ14] Config written over control serial link
// [RQ15] Control link: clock, data, enable
// [RQ16] Registers load stored defaults after reset
// [RQ17] Symbol tick every 48 reference cycles
// [RQ18] 8-PSK packs MSB first, no partial
module transmit_modulation_module #(
	parameter int unsigned PHASE_W = 16,
	parameter logic [15:0] DEFAULT_MODE = 16'h0000,
	parameter logic [15:0] DEFAULT_RAMP = 16'h0000,
	parameter int unsigned SYM_DIV = burst_link_pkg::SYM_REF_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	burst_link_if.device link,
	input wire logic [15:0] rx_word,
	input wire logic rx_word_valid,
	output logic rx_word_ready,
	output logic [2:0] symbol,
	output logic symbol_valid,
	output logic burst_active,
	output logic psk_mode,
	output logic [PHASE_W-1:0] cordic_phase,
	output logic [PHASE_W-1:0] amplitude,
	output logic signed [PHASE_W-1:0] phase_step,
	output logic [15:0] ramp_level,
	output logic defaults_loaded
);
	// Symbol counter is 6 bits; 8-PSK needs four radio clocks per symbol at least
	if (PHASE_W < 8 || PHASE_W > 32 || SYM_DIV < 4 || SYM_DIV > 64) begin : g_bad_param
		$error("transmit_modulation_module: parameter out of range");
	end

	////////////////////////////////////////////////////////////////
	// Radio clock divider and symbol tick
	logic [7:0] half_cnt_reg;
	logic rclk_reg;
	logic [5:0] ref_cnt_reg;
	logic sym_tick_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			half_cnt_reg <= 8'h00;
			rclk_reg <= 1'b0;
		end else if (half_cnt_reg == 8'(burst_link_pkg::RCLK_HALF - 1)) begin
			half_cnt_reg <= 8'h00;
			rclk_reg <= ~rclk_reg; // RQ11
		end else begin
			half_cnt_reg <= half_cnt_reg + 8'h01;
		end
	end
	assign link.radio_system_clock = rclk_reg; // RQ11

	wire ref_rise = (half_cnt_reg == 8'(burst_link_pkg::RCLK_HALF - 1)) && !rclk_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ref_cnt_reg <= 6'h00;
			sym_tick_reg <= 1'b0;
		end else begin
			sym_tick_reg <= 1'b0;
			if (ref_rise) begin
				if (ref_cnt_reg == 6'(SYM_DIV - 1)) begin
					ref_cnt_reg <= 6'h00;
					sym_tick_reg <= 1'b1; // RQ17 RQ3
				end else begin
					ref_cnt_reg <= ref_cnt_reg + 6'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [5:0] s1_reg;
	logic [5:0] s2_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s1_reg <= 6'h00;
			s2_reg <= 6'h00;
		end else begin
			s1_reg <= {link.serial_transfer_enable, link.serial_transfer_data, link.strobe,
				link.control_link_clock, link.control_link_data, link.control_link_enable};
			s2_reg <= s1_reg;
		end
	end
	wire tx_en = s2_reg[5];
	wire tx_dat = s2_reg[4];
	wire strobe_s = s2_reg[3];
	wire cclk = s2_reg[2];
	wire cdat = s2_reg[1];
	wire cen = s2_reg[0];

	////////////////////////////////////////////////////////////////
	// Control link slave and register file
	logic cclk_d_reg;
	logic [4:0] cbit_reg;
	logic [23:0] cshift_reg;
	logic [15:0] mode_reg;
	logic [15:0] ramp_reg;
	logic loaded_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cclk_d_reg <= 1'b0;
		end else begin
			cclk_d_reg <= cclk;
		end
	end
	wire cclk_rise = cclk && !cclk_d_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cbit_reg <= 5'h00;
			cshift_reg <= 24'h000000;
		end else if (!cen) begin
			cbit_reg <= 5'h00; // RQ15
		end else if (cclk_rise) begin
			cshift_reg <= {cshift_reg[22:0], cdat}; // RQ14
			cbit_reg <= cbit_reg + 5'h01;
		end
	end
	wire word_done = cen && cclk_rise && cbit_reg == 5'(burst_link_pkg::CTRL_WORD_W - 1);
	wire [23:0] word_in = {cshift_reg[22:0], cdat};

	// Stored defaults loaded one cycle after reset release
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= 16'h0000;
			ramp_reg <= 16'h0000;
			loaded_reg <= 1'b0;
		end else if (!loaded_reg) begin
			mode_reg <= DEFAULT_MODE; // RQ16
			ramp_reg <= DEFAULT_RAMP; // RQ16
			loaded_reg <= 1'b1;
		end else if (word_done && word_in[23]) begin
			if (word_in[22:16] == burst_link_pkg::MODE_REG_ADDR) mode_reg <= word_in[15:0]; // RQ14
			if (word_in[22:16] == burst_link_pkg::RAMP_REG_ADDR) ramp_reg <= word_in[15:0]; // RQ14
		end
	end

	////////////////////////////////////////////////////////////////
	// Burst framing: strobe arms, 148 symbols, tails at both ends
	logic strobe_d_reg;
	logic armed_reg;
	logic active_reg;
	logic psk_reg;
	logic [7:0] sym_cnt_reg;
	logic [2:0] pack_reg;
	logic [1:0] pack_cnt_reg;
	logic [2:0] held_reg;
	logic held_ok_reg;
	logic [2:0] sym_reg;
	logic sym_valid_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			strobe_d_reg <= 1'b0;
		end else begin
			strobe_d_reg <= strobe_s;
		end
	end

	// Serial bit capture on radio clock rising, qualified by enable
	logic rclk_d_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rclk_d_reg <= 1'b0;
		end else begin
			rclk_d_reg <= rclk_reg;
		end
	end
	wire bit_take = tx_en && rclk_reg && !rclk_d_reg; // RQ10
	wire [1:0] need = psk_reg ? 2'(burst_link_pkg::PSK_BITS - 1) : 2'h0;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pack_reg <= 3'h0;
			pack_cnt_reg <= 2'h0;
			held_reg <= 3'h0;
			held_ok_reg <= 1'b0;
		end else begin
			if (sym_tick_reg) held_ok_reg <= 1'b0;
			if (!active_reg) begin
				pack_cnt_reg <= 2'h0; // RQ18
			end else if (bit_take) begin
				if (pack_cnt_reg == need) begin
					held_reg <= psk_reg ? {pack_reg[1:0], tx_dat} : {2'h0, tx_dat}; // RQ4 RQ18
					held_ok_reg <= 1'b1;
					pack_cnt_reg <= 2'h0;
				end else begin
					pack_reg <= {pack_reg[1:0], tx_dat};
					pack_cnt_reg <= pack_cnt_reg + 2'h1;
				end
			end
		end
	end

	function automatic logic [2:0] idle_symbol(input logic psk);
		idle_symbol = psk ? burst_link_pkg::PSK_IDLE : {2'h0, burst_link_pkg::GMSK_IDLE_BIT};
	endfunction

	// Counter holds the index of the symbol about to be sent
	wire in_tail = sym_cnt_reg < 8'(burst_link_pkg::TAIL_SYMS)
		|| sym_cnt_reg >= 8'(burst_link_pkg::BURST_SYMS - burst_link_pkg::TAIL_SYMS);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			armed_reg <= 1'b0;
			active_reg <= 1'b0;
			psk_reg <= 1'b0;
			sym_cnt_reg <= 8'h00;
			sym_reg <= 3'h0;
			sym_valid_reg <= 1'b0;
		end else begin
			sym_valid_reg <= sym_tick_reg; // RQ3
			if (strobe_s && !strobe_d_reg && !active_reg) begin
				armed_reg <= 1'b1; // RQ13
				psk_reg <= mode_reg[burst_link_pkg::MODE_PSK_BIT]; // RQ1
			end
			if (sym_tick_reg) begin
				if (active_reg) begin
					if (sym_cnt_reg == 8'(burst_link_pkg::BURST_SYMS)) begin
						// Last of the 148 went out on the previous tick
						active_reg <= 1'b0; // RQ9
						sym_reg <= idle_symbol(psk_reg); // RQ5 RQ6
					end else begin
						if (in_tail) begin
							sym_reg <= psk_reg ? burst_link_pkg::PSK_TAIL : burst_link_pkg::GMSK_TAIL; // RQ7 RQ8
						end else begin
							sym_reg <= held_ok_reg ? held_reg : sym_reg;
						end
						sym_cnt_reg <= sym_cnt_reg + 8'h01;
					end
				end else begin
					// Idle: GMSK ones, 8-PSK all-ones symbol
					sym_reg <= idle_symbol(psk_reg); // RQ5 RQ6
					if (armed_reg) begin
						armed_reg <= 1'b0;
						active_reg <= 1'b1;
						// Symbol 0 goes out now
						sym_cnt_reg <= 8'h01;
						sym_reg <= psk_reg ? burst_link_pkg::PSK_TAIL : burst_link_pkg::GMSK_TAIL; // RQ7
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Polar paths: CORDIC-style phase/amplitude and phase derivative
	logic [PHASE_W-1:0] phase_reg;
	logic [PHASE_W-1:0] amp_reg;
	logic signed [PHASE_W-1:0] step_reg;
	function automatic logic [PHASE_W-1:0] psk_angle(input logic [2:0] s);
		psk_angle = {s, {(PHASE_W-3){1'b0}}};
	endfunction
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			phase_reg <= '0;
			amp_reg <= '0;
			step_reg <= '0;
		end else if (sym_valid_reg) begin
			if (psk_reg) begin
				step_reg <= $signed(psk_angle(sym_reg) - phase_reg); // RQ2
				phase_reg <= psk_angle(sym_reg); // RQ2 RQ1
				amp_reg <= {1'b0, {(PHASE_W-1){1'b1}}};
			end else begin
				// GMSK: +/- quarter turn per bit
				step_reg <= sym_reg[0] ? $signed({2'b01, {(PHASE_W-2){1'b0}}}) : $signed({2'b11, {(PHASE_W-2){1'b0}}});
				phase_reg <= phase_reg + (sym_reg[0] ? {2'b01, {(PHASE_W-2){1'b0}}} : {2'b11, {(PHASE_W-2){1'b0}}});
				amp_reg <= {1'b0, {(PHASE_W-1){1'b1}}};
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Receive return: word shifted MSB first on radio clock falls
	logic [15:0] rx_shift_reg;
	logic [4:0] rx_cnt_reg;
	logic rx_en_reg;
	logic rx_dat_reg;
	logic rx_mark_reg;
	logic rx_ready_reg;
	wire rclk_fall = !rclk_reg && rclk_d_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_shift_reg <= 16'h0000;
			rx_cnt_reg <= 5'h00;
			rx_en_reg <= 1'b0;
			rx_dat_reg <= 1'b0;
			rx_mark_reg <= 1'b0;
			rx_ready_reg <= 1'b0;
		end else begin
			rx_ready_reg <= rx_cnt_reg == 5'h00;
			if (rx_word_valid && rx_ready_reg) begin
				rx_shift_reg <= rx_word;
				rx_cnt_reg <= 5'h10;
				rx_ready_reg <= 1'b0;
			end else if (rclk_fall) begin
				if (rx_cnt_reg != 5'h00) begin
					rx_dat_reg <= rx_shift_reg[15]; // RQ12
					rx_en_reg <= 1'b1; // RQ12
					rx_mark_reg <= rx_cnt_reg == 5'h10; // RQ12
					rx_shift_reg <= {rx_shift_reg[14:0], 1'b0};
					rx_cnt_reg <= rx_cnt_reg - 5'h01;
				end else begin
					rx_en_reg <= 1'b0;
					rx_mark_reg <= 1'b0;
				end
			end
		end
	end
	assign link.rx_transfer_data = rx_dat_reg;
	assign link.rx_transfer_enable = rx_en_reg;
	assign link.receive_frame_marker = rx_mark_reg;
	assign rx_word_ready = rx_ready_reg;

	assign symbol = sym_reg;
	assign symbol_valid = sym_valid_reg;
	assign burst_active = active_reg;
	assign psk_mode = psk_reg;
	assign cordic_phase = phase_reg;
	assign amplitude = amp_reg;
	assign phase_step = step_reg;
	assign ramp_level = ramp_reg;
	assign defaults_loaded = loaded_reg;
endmodule
